/* src/pwmdc_pkg.sv */
/*
 package of the pwm duty compare block: register map, field layout,
 reset values and widths.
 assumes a 32-bit ahb-lite slave, one word per register.
*/
package pwmdc_pkg;
    localparam int CHANNELS     = 3;
    localparam int OUTPUTS      = 6;
    localparam int DUTY_W       = 14;
    localparam int COUNT_W      = 12;
    localparam int ADDR_W       = 8;
    // duty byte pairs: output k = 2*channel + side (0 high side, 1 low side)
    localparam logic [ADDR_W-1:0] DUTY_BASE  = 8'h00;
    localparam logic [ADDR_W-1:0] DUTY_HI    = 8'h00;
    localparam logic [ADDR_W-1:0] DUTY_LO    = 8'h04;
    localparam logic [ADDR_W-1:0] DUTY_STEP  = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h30;
    localparam logic [ADDR_W-1:0] OPTION_OFF = 8'h34;
    localparam int   SIGN_BIT   = 7;
    localparam logic [7:0] HI_MASK = 8'h9F;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    typedef logic [DUTY_W-1:0] pwmdc_duty_t;
endpackage

/* src/pwmdc_bus_if.sv */
/*
 interface carrying register accesses from the bus slave to the core.
 assumes one clock domain.
*/
`timescale 1ns/1ps
interface pwmdc_bus_if;
    logic        wrEn;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output wrEn, output addr, output wdata, input rdata);
    modport core (input wrEn, input addr, input wdata, output rdata);
endinterface

/* src/pwmdc_ahb_slave.sv */
/*
 ahb-lite slave: captures the address phase, writes in the data phase,
 registers read data. zero wait states, always okay.
 assumes single word transfers.
*/
`timescale 1ns/1ps
module pwmdc_ahb_slave
    import pwmdc_pkg::*;
(
    // clock
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    // ahb
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    // core side
    pwmdc_bus_if.slave       bus
);
    logic       pendWr;
    logic [7:0] pendAddr;
    logic       take;

    assign take = hsel && hready && htrans == HTRANS_NONSEQ;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pendWr   <= 1'b0;
            pendAddr <= 8'h00;
        end else if (clkEn) begin
            pendWr   <= take && hwrite && hsize == HSIZE_WORD;
            if (take)
                pendAddr <= haddr[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            hrdata <= 32'h0000_0000;
        else if (clkEn && take && !hwrite)
            hrdata <= bus.rdata;
    end

    assign bus.wrEn  = pendWr && clkEn;
    assign bus.addr  = take && !hwrite ? haddr[7:0] : pendAddr;
    assign bus.wdata = hwdata;
endmodule // pwmdc_ahb_slave

/* src/pwmdc_compare.sv */
/*
 one output comparator: signed duty against the running count.
 assumes count and reload are from the period counter outside.
*/
`timescale 1ns/1ps
module pwmdc_compare
    import pwmdc_pkg::*;
(
    // values
    input  wire pwmdc_pkg::pwmdc_duty_t     duty,
    input  wire logic [COUNT_W-1:0]         count,
    input  wire logic [COUNT_W-1:0]         reload,
    // result
    output logic                            onState
);
    logic [DUTY_W-2:0] mag;
    assign mag = duty[DUTY_W-2:0];
    always_comb begin
        if (duty[DUTY_W-1])
            onState = 1'b0;
        else if (mag > {1'b0, reload})
            onState = 1'b1;
        else
            onState = {1'b0, count} < mag;
    end
endmodule // pwmdc_compare

/* src/pwmdc_top.sv */
/*
 pwm duty cycle compare path: three channels, high and low side duty
 holding registers, transfer at reload, compare and off-state outputs.
 assumes external period counter supplies count, reload value and the
 reload event; option bits come from nonvolatile strap inputs.
*/
`timescale 1ns/1ps
// Contract
// - compare 14-bit signed duty with count
// - reads return holding registers
// - new duty takes effect at reload
// - enables and off-state from option bits
// - software cannot change option values
// - three channels, high/low sides, byte halves
// - negative duty forces output off
// - duty above reload forces output on
// - high byte bits 5,6 zero
module pwmdc_top
    import pwmdc_pkg::*;
#(
    parameter int NUM_CH = CHANNELS
)(
    // clock
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                clkEn,
    // ahb-lite
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // period counter
    input  wire logic [COUNT_W-1:0]  pwmCount,
    input  wire logic [COUNT_W-1:0]  reloadValue,
    input  wire logic                reloadEvent,
    // option bits
    input  wire logic [5:0]          optChanEn,
    input  wire logic [5:0]          optOffState,
    // outputs
    output logic      [5:0]          pwmOut
);
    ////////////////////////////////////////////////////////////////////
    // elaboration checks
    initial begin
        if (NUM_CH != CHANNELS)
            $error("NUM_CH must be 3");
        if (OUTPUTS != 2 * NUM_CH)
            $error("OUTPUTS must be two per channel");
        if (DUTY_W != 14)
            $error("DUTY_W must be 14");
        if (COUNT_W >= DUTY_W - 1)
            $error("COUNT_W must stay below the duty magnitude");
        if (SIGN_BIT != 7)
            $error("SIGN_BIT must be the top bit of the high byte");
        if (HI_MASK != 8'h9F)
            $error("HI_MASK must clear the two reserved bits");
        if (DUTY_LO >= DUTY_STEP)
            $error("DUTY_LO must lie inside one duty pair");
        if (STATUS_OFF < DUTY_STEP * OUTPUTS)
            $error("STATUS_OFF overlaps the duty pairs");
        if (OPTION_OFF == STATUS_OFF)
            $error("OPTION_OFF must differ from STATUS_OFF");
    end

    ////////////////////////////////////////////////////////////////////
    // helpers

    // address of one byte of one duty pair
    function automatic logic isDuty(input logic [7:0] a,
                                    input int k,
                                    input logic [7:0] fld);
        isDuty = a == 8'(DUTY_BASE + DUTY_STEP * k + fld);
    endfunction

    // sign, five magnitude bits, low byte
    function automatic pwmdc_duty_t joinDuty(input logic [7:0] hi,
                                             input logic [7:0] lo);
        joinDuty = {hi[SIGN_BIT], hi[4:0], lo};
    endfunction

    // enabled and on: inverse of the off level
    function automatic logic outLevel(input logic en,
                                      input logic on,
                                      input logic off);
        outLevel = en && on ? !off : off;
    endfunction

    // one byte register on the word bus
    function automatic logic [31:0] byteWord(input logic [7:0] v);
        byteWord = {24'h000000, v};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus
    pwmdc_bus_if bus ();
    pwmdc_ahb_slave u_slave (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .hsel    (hsel),
        .haddr   (haddr),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hsize   (hsize),
        .hwdata  (hwdata),
        .hready  (hready),
        .hrdata  (hrdata),
        .bus     (bus.slave)
    );

    // zero wait states once out of reset
    always_ff @(posedge clk) begin
        if (sys_rst)
            hreadyout <= 1'b0;
        else if (clkEn)
            hreadyout <= 1'b1;
    end

    // response is always okay
    always_ff @(posedge clk) begin
        if (sys_rst)
            hresp <= 1'b0;
        else if (clkEn)
            hresp <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // option bits latched once after reset
    logic [5:0] chanEn;
    logic [5:0] offState;
    logic       optLoaded;
    logic       optTake;

    assign optTake = clkEn && !optLoaded;

    always_ff @(posedge clk) begin
        if (sys_rst)
            optLoaded <= 1'b0;
        else if (optTake)
            optLoaded <= 1'b1;
    end

    // no bus path reaches these
    always_ff @(posedge clk) begin
        if (sys_rst)
            chanEn <= 6'h00;
        else if (optTake)
            chanEn <= optChanEn;
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            offState <= 6'h00;
        else if (optTake)
            offState <= optOffState;
    end

    ////////////////////////////////////////////////////////////////////
    // address decode
    logic [OUTPUTS-1:0] hiHit;
    logic [OUTPUTS-1:0] loHit;
    logic               statusHit;
    logic               optionHit;
    logic               reloadTake;

    always_comb begin
        for (int i = 0; i < OUTPUTS; i++) begin
            hiHit[i] = isDuty(bus.addr, i, DUTY_HI);
            loHit[i] = isDuty(bus.addr, i, DUTY_LO);
        end
    end

    assign statusHit  = bus.addr == STATUS_OFF;
    assign optionHit  = bus.addr == OPTION_OFF;
    assign reloadTake = clkEn && reloadEvent;

    ////////////////////////////////////////////////////////////////////
    // holding, active and output per side
    logic [7:0]   dutyHi  [OUTPUTS];
    logic [7:0]   dutyLo  [OUTPUTS];
    pwmdc_duty_t  active  [OUTPUTS];
    logic [5:0]   onState;
    logic [5:0]   next_pwmOut;

    genvar k;
    generate
        for (k = 0; k < OUTPUTS; k++) begin : g_out
            // holding high byte, reserved bits forced low
            always_ff @(posedge clk) begin
                if (sys_rst)
                    dutyHi[k] <= BYTE_RST;
                else if (bus.wrEn && hiHit[k])
                    dutyHi[k] <= bus.wdata[7:0] & HI_MASK;
            end

            // holding low byte
            always_ff @(posedge clk) begin
                if (sys_rst)
                    dutyLo[k] <= BYTE_RST;
                else if (bus.wrEn && loHit[k])
                    dutyLo[k] <= bus.wdata[7:0];
            end

            // comparator value, moved only at reload
            always_ff @(posedge clk) begin
                if (sys_rst)
                    active[k] <= '0;
                else if (reloadTake)
                    active[k] <= joinDuty(dutyHi[k], dutyLo[k]);
            end

            pwmdc_compare u_cmp (
                .duty    (active[k]),
                .count   (pwmCount),
                .reload  (reloadValue),
                .onState (onState[k])
            );

            assign next_pwmOut[k] = outLevel(chanEn[k], onState[k],
                                             offState[k]);

            always_ff @(posedge clk) begin
                if (sys_rst)
                    pwmOut[k] <= 1'b0;
                else if (clkEn)
                    pwmOut[k] <= next_pwmOut[k];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // read mux
    logic [31:0] statusWord;
    logic [31:0] optionWord;

    assign statusWord = {26'h0000000, pwmOut};
    assign optionWord = {18'h00000, offState, 2'h0, chanEn};

    always_comb begin
        bus.rdata = 32'h0000_0000;
        for (int i = 0; i < OUTPUTS; i++) begin
            if (hiHit[i])
                bus.rdata = byteWord(dutyHi[i]);
            if (loHit[i])
                bus.rdata = byteWord(dutyLo[i]);
        end
        if (statusHit)
            bus.rdata = statusWord;
        if (optionHit)
            bus.rdata = optionWord;
    end
endmodule // pwmdc_top

/* dv/pwmdc_chk.sv */
/* port checker of pwmdc_top.
 assumes hready tied to hreadyout, option straps held constant. */
`timescale 1ns/1ps
module pwmdc_chk
    import pwmdc_pkg::*;
(
    // watched ports
    input wire logic         clk,
    input wire logic         sys_rst,
    input wire logic         hsel,
    input wire logic [31:0]  haddr,
    input wire logic [1:0]   htrans,
    input wire logic         hwrite,
    input wire logic         hready,
    input wire logic [31:0]  hrdata,
    input wire logic         hresp,
    input wire logic [11:0]  pwmCount,
    input wire logic [11:0]  reloadValue,
    input wire logic         reloadEvent,
    input wire logic [5:0]   optChanEn,
    input wire logic [5:0]   optOffState,
    input wire logic [5:0]   pwmOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic       rd;
    logic [1:0] up;
    logic [7:0] a;
    assign a = haddr[7:0];
    assign rd = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    always_ff @(posedge clk) begin
        if (sys_rst) up <= 2'h0;
        else if (up != 2'h3) up <= up + 2'h1;
    end
    ////////////////////////////////////////
    resp_okay_a: assert property (up == 2'h3 |-> !hresp)
        else $error("error response seen");
    opt_read_a: assert property (rd && a == OPTION_OFF |=>
        hrdata == {18'h0, optOffState, 2'h0, optChanEn})
        else $error("option read wrong");
    hi_zero_a: assert property (rd && a < STATUS_OFF && !a[2]
        |=> hrdata[6:5] == 2'h0) else $error("reserved duty bits set");
    byte_only_a: assert property (rd && a < STATUS_OFF
        |=> hrdata[31:8] == 24'h0) else $error("duty read too wide");
    unmapped_a: assert property (rd && a > OPTION_OFF |=> hrdata == 0)
        else $error("unmapped read not zero");
    status_a: assert property (rd && a == STATUS_OFF |=>
        hrdata == {26'h0, $past(pwmOut)}) else $error("status wrong");
    off_level_a: assert property (up == 2'h3 |->
        (~optChanEn & (pwmOut ^ optOffState)) == 6'h00)
        else $error("disabled output not at off level");
    hold_duty_a: assert property ((up == 2'h3 && !reloadEvent &&
        $stable(pwmCount) && $stable(reloadValue)) [*3] |=> $stable(pwmOut))
        else $error("output moved without reload");
    cover property (rd && a == STATUS_OFF);
    cover property (reloadEvent ##2 $changed(pwmOut));
    cover property (hsel && htrans == HTRANS_NONSEQ && hwrite);
endmodule // pwmdc_chk
bind pwmdc_top pwmdc_chk u_chk(.clk, .sys_rst, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hrdata, .hresp, .pwmCount, .reloadValue,
    .reloadEvent, .optChanEn, .optOffState, .pwmOut);

/* dv/test_pwm_duty_cycle_compare.sv */
/* bench of pwmdc_top through its ahb-lite port and period inputs.
 assumes the checker is bound to the top module. */
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin errorCnt++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module test_pwm_duty_cycle_compare;
    import pwmdc_pkg::*;
    localparam logic [5:0] EN = 6'h1F;
    localparam logic [5:0] OFF = 6'h20;
    logic        clk, sysRst = 1'b1, hwrite = 1'b0, hreadyout, hresp;
    logic        reloadEvent = 1'b0, clkEn = 1'b1;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [11:0] pwmCount = 12'h032, reloadValue = 12'h064;
    logic [5:0]  pwmOut;
    logic [7:0]  hiv [6] = '{8'h00, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h00};
    logic [7:0]  lov [6] = '{8'h50, 8'h14, 8'h10, 8'hC8, 8'h32, 8'h01};
    int          errorCnt = 0, nChecks = 0;
    pwmdc_top u_dut(.clk(clk), .sys_rst(sysRst), .clkEn(clkEn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pwmCount(pwmCount), .reloadValue(reloadValue),
        .reloadEvent(reloadEvent), .optChanEn(EN), .optOffState(OFF),
        .pwmOut(pwmOut));
    ////////////////////////////////////////
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        htrans <= HTRANS_NONSEQ;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 0, q);
        `CHK(q, e)
    endtask
    task automatic step(input logic [5:0] e);
        repeat (3) @(posedge clk);
        `CHK(pwmOut, e)
    endtask
    task give_verdict;
        if (errorCnt == 0 && nChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        errorCnt++;
        give_verdict;
    end
    initial begin
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(OPTION_OFF, {18'h0, OFF, 2'h0, EN});
        wr(OPTION_OFF, 32'hFFFFFFFF);
        rd(OPTION_OFF, {18'h0, OFF, 2'h0, EN});
        rd(8'h38, 32'h0);
        for (int k = 0; k < 6; k++) begin
            wr(DUTY_STEP * 8'(k), {24'h0, hiv[k]});
            wr(DUTY_STEP * 8'(k) + DUTY_LO, {24'h0, lov[k]});
        end
        for (int k = 0; k < 6; k++) begin
            rd(DUTY_STEP * 8'(k), {24'h0, hiv[k] & HI_MASK});
            rd(DUTY_STEP * 8'(k) + DUTY_LO, {24'h0, lov[k]});
        end
        rd(STATUS_OFF, {26'h0, OFF});
        reloadEvent <= 1'b1;
        @(posedge clk);
        reloadEvent <= 1'b0;
        step(6'h29);
        pwmCount <= 12'h05A;
        step(6'h28);
        pwmCount <= 12'h00A;
        step(6'h3B);
        rd(STATUS_OFF, {26'h0, 6'h3B});
        wr(DUTY_LO, 32'h0);
        step(6'h3B);
        reloadEvent <= 1'b1;
        @(posedge clk);
        reloadEvent <= 1'b0;
        step(6'h3A);
        wr(DUTY_LO, 32'h50);
        clkEn <= 1'b0;
        reloadEvent <= 1'b1;
        @(posedge clk);
        reloadEvent <= 1'b0;
        step(6'h3A);
        clkEn <= 1'b1;
        reloadEvent <= 1'b1;
        @(posedge clk);
        reloadEvent <= 1'b0;
        step(6'h3B);
        give_verdict;
    end
endmodule // test_pwm_duty_cycle_compare
